// ### design/psic_host_end.sv
`timescale 1ns/100ps
module psic_host_end
  import psic_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       srst_in,
  // bus pins
  psic_i2c_if.host        bus,
  // request
  input  wire logic       req_valid_in,
  input  wire logic [7:0] req_cmd_in,
  input  wire logic [7:0] req_param_in,
  output logic            ready_out,
  // answer
  output logic [7:0]      rd_data_out,
  output logic            rd_valid_out,
  output logic            done_out,
  output logic            nack_out
);

  // ==========================================================================
  // quarter-bit enable
  psic_host_state_t state_q;
  logic [15:0]      div_q;
  logic             tick;
  logic [1:0]       ph_q;
  logic [3:0]       bit_q;
  logic [6:0]       step_q;
  logic [7:0]       cmd_q;
  logic [7:0]       param_q;
  logic [7:0]       tx_q;
  logic [7:0]       rx_q;
  logic             is_read_q;
  logic             nack_q;

  assign tick = (div_q == 16'(SCL_QUARTER_CYC - 1));

  always_ff @(posedge core_clk_in) begin
    if (srst_in || state_q == H_IDLE || tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // byte sent at each step; data steps release the line for the sensor
  function automatic logic [7:0] byte_for(input logic [6:0] step);
    if (step == 7'h00) begin
      byte_for = {PSIC_ADDR_BYTE[7:1], 1'b0};
    end else if (step == 7'h01) begin
      byte_for = cmd_q;
    end else if (step == STEP_ADDR_READ) begin
      byte_for = is_read_q ? {PSIC_ADDR_BYTE[7:1], 1'b1} : param_q;
    end else begin
      byte_for = BYTE_IDLE;
    end
  endfunction: byte_for

  // ==========================================================================
  // transfer sequencer
  always_ff @(posedge core_clk_in) begin
    bus.host_scl_out <= 1'b0;
    bus.host_sda_out <= 1'b0;
    rd_valid_out     <= 1'b0;
    done_out         <= 1'b0;
    nack_out         <= 1'b0;
    if (srst_in) begin
      state_q           <= H_IDLE;
      bus.host_scl_oe_n <= 1'b1;
      bus.host_sda_oe_n <= 1'b1;
      ready_out         <= 1'b0;
      ph_q              <= 2'h0;
      bit_q             <= 4'h0;
      step_q            <= 7'h00;
      cmd_q             <= BYTE_ZERO;
      param_q           <= BYTE_ZERO;
      tx_q              <= BYTE_IDLE;
      rx_q              <= BYTE_ZERO;
      rd_data_out       <= BYTE_ZERO;
      is_read_q         <= 1'b0;
      nack_q            <= 1'b0;
    end else begin
      case (state_q)
        H_IDLE: begin
          ready_out <= 1'b1;
          if (req_valid_in && ready_out) begin
            ready_out <= 1'b0;
            cmd_q     <= req_cmd_in;
            param_q   <= req_param_in;
            is_read_q <= (req_cmd_in == CMD_READ_COUNT) | (req_cmd_in == CMD_READ_MASS);
            step_q    <= 7'h00;
            ph_q      <= 2'h0;
            state_q   <= H_START;
          end
        end
        H_START: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: bus.host_sda_oe_n <= 1'b1;
            2'h1: bus.host_scl_oe_n <= 1'b1;
            2'h2: bus.host_sda_oe_n <= 1'b0;
            default: begin
              bus.host_scl_oe_n <= 1'b0;
              tx_q              <= byte_for(step_q);
              bit_q             <= 4'h0;
              state_q           <= H_BIT;
            end
          endcase
        end
        H_BIT: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: begin
              if (bit_q != BIT_ACK) begin
                bus.host_sda_oe_n <= tx_q[7];
              end else begin
                bus.host_sda_oe_n <= (step_q < STEP_FIRST_DATA);
              end
            end
            2'h1: bus.host_scl_oe_n <= 1'b1;
            2'h2: begin
              if (bit_q != BIT_ACK) begin
                rx_q <= {rx_q[6:0], bus.sda};
                tx_q <= {tx_q[6:0], 1'b1};
              end else begin
                nack_q <= bus.sda;
              end
            end
            default: begin
              bus.host_scl_oe_n <= 1'b0;
              bit_q             <= bit_q + 4'h1;
              if (bit_q == BIT_ACK) begin
                bit_q <= 4'h0;
                if (step_q < STEP_FIRST_DATA && nack_q) begin
                  nack_out <= 1'b1;
                  state_q  <= H_STOP;
                end else if (step_q >= STEP_FIRST_DATA) begin
                  rd_data_out  <= rx_q;
                  rd_valid_out <= 1'b1;
                  step_q       <= step_q + 7'h01;
                  if (step_q == STEP_LAST_DATA) begin
                    state_q <= H_STOP;
                  end
                end else if (step_q == 7'h01 && is_read_q) begin
                  // repeated start before the read address
                  step_q  <= STEP_ADDR_READ;
                  state_q <= H_START;
                end else if (step_q == STEP_ADDR_READ && !is_read_q) begin
                  state_q <= H_STOP;
                end else begin
                  step_q <= step_q + 7'h01;
                  tx_q   <= byte_for(step_q + 7'h01);
                end
              end
            end
          endcase
        end
        default: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: bus.host_sda_oe_n <= 1'b0;
            2'h1: bus.host_scl_oe_n <= 1'b1;
            2'h2: bus.host_sda_oe_n <= 1'b1;
            default: begin
              done_out <= 1'b1;
              state_q  <= H_IDLE;
            end
          endcase
        end
      endcase
    end
  end

endmodule: psic_host_end

// ### design/psic_i2c_if.sv
`timescale 1ns/100ps
interface psic_i2c_if;

  // ==========================================================================
  // open-drain drivers, enable low while driving
  logic host_scl_out;
  logic host_scl_oe_n;
  logic host_sda_out;
  logic host_sda_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;
  wire  scl;
  wire  sda;

  // pull-up: a line is low while any enabled driver pulls it low
  assign scl = host_scl_oe_n | host_scl_out;
  assign sda = (host_sda_oe_n | host_sda_out) & (dev_sda_oe_n | dev_sda_out);

  modport host (
    input  scl,
    input  sda,
    output host_scl_out,
    output host_scl_oe_n,
    output host_sda_out,
    output host_sda_oe_n
  );

  modport sensor (
    input  scl,
    input  sda,
    output dev_sda_out,
    output dev_sda_oe_n
  );

endinterface: psic_i2c_if

// ### design/psic_pkg.sv
package psic_pkg;

  // ==========================================================================
  // bus addressing and command codes
  localparam logic [7:0] PSIC_ADDR_BYTE    = 8'h93;
  localparam logic [7:0] CMD_MEASURE       = 8'h20;
  localparam logic [7:0] CMD_READ_COUNT    = 8'h21;
  localparam logic [7:0] CMD_READ_MASS     = 8'h22;
  localparam logic [7:0] CMD_CLEAN         = 8'h23;
  localparam logic [7:0] CMD_POWER_SAVE    = 8'h24;
  localparam logic [7:0] PARAM_OFF         = 8'h00;
  localparam logic [7:0] PARAM_ON          = 8'h01;
  localparam logic [7:0] BYTE_ZERO         = 8'h00;
  localparam logic [7:0] BYTE_IDLE         = 8'hFF;

  // ==========================================================================
  // readback layout
  localparam logic [5:0] READ_LEN          = 6'h3F;
  localparam int         BIN_COUNT         = 7;
  localparam int         BIN_BYTES         = 8;
  localparam int         BIN_VEC_W         = BIN_COUNT * BIN_BYTES * 8;
  localparam int         MASS_FRAC_SCALE   = 10000;

  // ==========================================================================
  // function state flag positions
  localparam int         FLAG_FAN_BIT      = 0;
  localparam int         FLAG_CLEAN_BIT    = 1;
  localparam int         FLAG_SAVE_BIT     = 2;
  localparam logic [2:0] FLAGS_RST         = 3'h0;

  // ==========================================================================
  // bit framing
  localparam logic [3:0] BIT_ACK           = 4'h8;
  localparam logic [3:0] BIT_END           = 4'h9;
  localparam logic [6:0] STEP_ADDR_READ    = 7'h02;
  localparam logic [6:0] STEP_FIRST_DATA   = 7'h03;
  localparam logic [6:0] STEP_LAST_DATA    = 7'h41;

  // ==========================================================================
  // timing
  localparam int         CLK_PERIOD_NS     = 10;
  // short quarter keeps a whole read near 12k cycles; raise it for a slow bus
  localparam int         SCL_QUARTER_NS    = 50;
  localparam int         SCL_QUARTER_CYC   = SCL_QUARTER_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // state encodings
  typedef enum logic [5:0] {
    D_IDLE  = 6'h01,
    D_ADDR  = 6'h02,
    D_CMD   = 6'h04,
    D_PARAM = 6'h08,
    D_READ  = 6'h10,
    D_SKIP  = 6'h20
  } psic_dev_state_t;

  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_START = 4'h2,
    H_BIT   = 4'h4,
    H_STOP  = 4'h8
  } psic_host_state_t;

endpackage: psic_pkg

// ### design/psic_sensor_end.sv
// Function
// - command 0x20 with 0x1 starts measuring
// - command 0x20 with 0x0 stops measuring
// - 0x21 then read returns 63 count bytes
// - 0x22 then read returns 63 mass bytes
// - command 0x23 with 0x1 starts cleaning
// - command 0x23 with 0x0 stops cleaning
// - command 0x24 with 0x1 enters power saving
// - command 0x24 with 0x0 leaves power saving
// - count readback: seven 8-byte bins, smallest first
// - mass value: 4 integer, 4 fraction bytes
// - status bits: fan, cleaning, power saving
`timescale 1ns/100ps
module psic_sensor_end
  import psic_pkg::*;
(
  // clock and reset
  input  wire logic                 core_clk_in,
  input  wire logic                 srst_in,
  // bus pins
  psic_i2c_if.sensor                bus,
  // measured data, bin 0 in the top 64 bits
  input  wire logic [BIN_VEC_W-1:0] particle_count_bins_in,
  input  wire logic [BIN_VEC_W-1:0] mass_concentration_bins_in,
  input  wire logic                 fan_on_in,
  // function controls
  output logic                      measure_en_out,
  output logic                      cleaning_en_out,
  output logic                      power_saving_state_out,
  output logic [2:0]                function_state_flags_out
);

  // ==========================================================================
  // line sampling and conditions
  logic                 scl_q;
  logic                 sda_q;
  logic                 scl_rise;
  logic                 scl_fall;
  logic                 start_seen;
  logic                 stop_seen;
  psic_dev_state_t      state_q;
  logic [3:0]           cnt_q;
  logic [7:0]           sh_q;
  logic [7:0]           cmd_q;
  logic [5:0]           idx_q;
  logic [BIN_VEC_W-1:0] snap_q;
  logic [7:0]           tx_q;
  logic                 addr_hit;
  logic                 byte_done;
  logic                 byte_end;
  logic                 read_cmd;

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= bus.scl;
      sda_q <= bus.sda;
    end
  end

  assign scl_rise   = bus.scl & ~scl_q;
  assign scl_fall   = ~bus.scl & scl_q;
  assign start_seen = scl_q & bus.scl & sda_q & ~bus.sda;
  assign stop_seen  = scl_q & bus.scl & ~sda_q & bus.sda;
  assign addr_hit   = (sh_q[7:1] == PSIC_ADDR_BYTE[7:1]);
  assign byte_done  = scl_fall & (cnt_q == BIT_ACK);
  assign byte_end   = scl_fall & (cnt_q == BIT_END);
  assign read_cmd   = (cmd_q == CMD_READ_COUNT) | (cmd_q == CMD_READ_MASS);

  // ==========================================================================
  // byte framing and transfer state
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state_q <= D_IDLE;
      cnt_q   <= 4'h0;
      sh_q    <= BYTE_ZERO;
    end else if (start_seen) begin
      state_q <= D_ADDR;
      cnt_q   <= 4'h0;
    end else if (stop_seen) begin
      state_q <= D_IDLE;
      cnt_q   <= 4'h0;
    end else begin
      if (scl_rise && state_q != D_IDLE) begin
        if (cnt_q < BIT_ACK) begin
          sh_q <= {sh_q[6:0], bus.sda};
        end
        // host nack ends the read, the line must stay free for the stop
        if (cnt_q == BIT_ACK && state_q == D_READ && bus.sda) begin
          state_q <= D_SKIP;
        end
        cnt_q <= cnt_q + 4'h1;
      end
      if (byte_done) begin
        case (state_q)
          D_ADDR: begin
            if (!addr_hit) begin
              state_q <= D_SKIP;
            end else if (!sh_q[0]) begin
              state_q <= D_CMD;
            end else if (read_cmd) begin
              state_q <= D_READ;
            end else begin
              state_q <= D_SKIP;
            end
          end
          D_CMD:   state_q <= D_PARAM;
          D_PARAM: state_q <= D_SKIP;
          default: state_q <= state_q;
        endcase
      end
      if (byte_end) begin
        cnt_q <= 4'h0;
        if (state_q == D_READ && idx_q == READ_LEN) begin
          state_q <= D_SKIP;
        end
      end
    end
  end

  // ==========================================================================
  // command capture
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      cmd_q <= BYTE_ZERO;
    end else if (byte_done && state_q == D_CMD) begin
      cmd_q <= sh_q;
    end
  end

  // ==========================================================================
  // read data path
  // snapshot at the address byte so a transfer never mixes two measurements
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      snap_q <= '0;
      tx_q   <= BYTE_ZERO;
      idx_q  <= 6'h00;
    end else if (byte_done && state_q == D_ADDR) begin
      idx_q <= 6'h00;
      if (cmd_q == CMD_READ_COUNT) begin
        snap_q <= particle_count_bins_in;
      end else begin
        snap_q <= mass_concentration_bins_in;
      end
    end else if (byte_end && state_q == D_READ && idx_q != READ_LEN) begin
      // bytes past the seven bins shift in as zero
      tx_q   <= snap_q[BIN_VEC_W-1 -: 8];
      snap_q <= {snap_q[BIN_VEC_W-9:0], BYTE_ZERO};
      idx_q  <= idx_q + 6'h01;
    end
  end

  // ==========================================================================
  // data line driver
  // changes on scl falls, else only releases at start or stop, so data never moves while scl is high
  always_ff @(posedge core_clk_in) begin
    bus.dev_sda_out <= 1'b0;
    if (srst_in || start_seen || stop_seen) begin
      bus.dev_sda_oe_n <= 1'b1;
    end else if (scl_fall) begin
      if (cnt_q == BIT_ACK) begin
        if ((state_q == D_ADDR && addr_hit && (!sh_q[0] || read_cmd)) ||
            state_q == D_CMD || state_q == D_PARAM) begin
          bus.dev_sda_oe_n <= 1'b0;
        end else begin
          bus.dev_sda_oe_n <= 1'b1;
        end
      end else if (cnt_q == BIT_END) begin
        if (state_q == D_READ && idx_q != READ_LEN) begin
          bus.dev_sda_oe_n <= snap_q[BIN_VEC_W-1];
        end else begin
          bus.dev_sda_oe_n <= 1'b1;
        end
      end else if (state_q == D_READ && cnt_q != 4'h0) begin
        bus.dev_sda_oe_n <= tx_q[3'(4'h7 - cnt_q)];
      end else begin
        bus.dev_sda_oe_n <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // function controls
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      measure_en_out         <= 1'b0;
      cleaning_en_out        <= 1'b0;
      power_saving_state_out <= 1'b0;
    end else if (byte_done && state_q == D_PARAM) begin
      case (cmd_q)
        CMD_MEASURE: begin
          if (sh_q == PARAM_ON) begin
            measure_en_out <= 1'b1;
          end else if (sh_q == PARAM_OFF) begin
            measure_en_out <= 1'b0;
          end
        end
        CMD_CLEAN: begin
          if (sh_q == PARAM_ON) begin
            cleaning_en_out <= 1'b1;
          end else if (sh_q == PARAM_OFF) begin
            cleaning_en_out <= 1'b0;
          end
        end
        CMD_POWER_SAVE: begin
          if (sh_q == PARAM_ON) begin
            power_saving_state_out <= 1'b1;
          end else if (sh_q == PARAM_OFF) begin
            power_saving_state_out <= 1'b0;
          end
        end
        default: begin
          measure_en_out <= measure_en_out;
        end
      endcase
    end
  end

  // ==========================================================================
  // function state flags
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      function_state_flags_out <= FLAGS_RST;
    end else begin
      function_state_flags_out[FLAG_FAN_BIT]   <= fan_on_in;
      function_state_flags_out[FLAG_CLEAN_BIT] <= cleaning_en_out;
      function_state_flags_out[FLAG_SAVE_BIT]  <= power_saving_state_out;
    end
  end

endmodule: psic_sensor_end

// ### tb/psic_asserts.sv
`timescale 1ns/100ps
module psic_asserts
  import psic_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // host drivers
  input wire logic host_scl_out,
  input wire logic host_scl_oe_n,
  input wire logic host_sda_out,
  input wire logic host_sda_oe_n,
  // sensor drivers
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe_n,
  // resolved lines
  input wire logic scl,
  input wire logic sda
);
  localparam int LOW_MIN  = 2 * SCL_QUARTER_CYC - 1;
  localparam int LOW_MAX  = 2 * SCL_QUARTER_CYC + 1;
  localparam int HOLD_MIN = SCL_QUARTER_CYC - 1;
  localparam int HOLD_MAX = SCL_QUARTER_CYC + 1;

  // ==========================================================================
  // scl run length
  // saturates so a long idle high never wraps into a legal figure
  logic        scl_prev_q;
  logic [15:0] run_q;

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      scl_prev_q <= 1'b1;
      run_q      <= 16'h0001;
    end else begin
      scl_prev_q <= scl;
      if (scl != scl_prev_q) begin
        run_q <= 16'h0001;
      end else if (run_q != 16'hFFFF) begin
        run_q <= run_q + 16'h0001;
      end
    end
  end

  // ==========================================================================
  // properties
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (srst_in);

  property p_dev_out_zero;
    dev_sda_out == 1'b0;
  endproperty
  a_dev_out_zero: assert property (p_dev_out_zero)
    else $error("sensor drives sda high");

  property p_host_out_zero;
    (host_scl_out == 1'b0) && (host_sda_out == 1'b0);
  endproperty
  a_host_out_zero: assert property (p_host_out_zero)
    else $error("host drives a line high");

  property p_dev_scl_low;
    $changed(dev_sda_oe_n) |-> !scl;
  endproperty
  a_dev_scl_low: assert property (p_dev_scl_low)
    else $error("sensor moved sda while scl high");

  property p_scl_low_len;
    $rose(scl) |-> (run_q >= LOW_MIN) && (run_q <= LOW_MAX);
  endproperty
  a_scl_low_len: assert property (p_scl_low_len)
    else $error("scl low phase has wrong length");

  property p_host_only_high;
    $changed(sda) && scl && $past(scl) |-> $changed(host_sda_oe_n);
  endproperty
  a_host_only_high: assert property (p_host_only_high)
    else $error("sda changed with scl high not by host");

  property p_start_hold;
    $fell(sda) && scl |-> ##[HOLD_MIN:HOLD_MAX] $fell(scl);
  endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("start not followed by scl fall in time");

  property p_stop_idle;
    $rose(sda) && scl |-> (scl && dev_sda_oe_n) [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("bus not idle after stop");

  property p_reset_release;
    $fell(srst_in) |-> host_scl_oe_n && host_sda_oe_n && dev_sda_oe_n;
  endproperty
  a_reset_release: assert property (p_reset_release)
    else $error("lines not released after reset");

  // ==========================================================================
  // coverage
  c_start: cover property ($fell(sda) && scl);
  c_stop:  cover property ($rose(sda) && scl);
  c_ack:   cover property ($fell(dev_sda_oe_n));
  c_low:   cover property ($rose(scl));

endmodule: psic_asserts

// ### tb/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import psic_pkg::*;
;
  localparam int N_WR     = 8;
  localparam int XFER_MAX = 20000;

  logic                 core_clk_in = 1'b0;
  logic                 srst_in;
  logic                 req_valid_in;
  logic [7:0]           req_cmd_in;
  logic [7:0]           req_param_in;
  logic                 fan_on_in;
  logic [BIN_VEC_W-1:0] count_bins;
  logic [BIN_VEC_W-1:0] mass_bins;
  logic                 ready_out;
  logic [7:0]           rd_data_out;
  logic                 rd_valid_out;
  logic                 done_out;
  logic                 nack_out;
  logic                 measure_en_out;
  logic                 cleaning_en_out;
  logic                 save_out;
  logic [2:0]           flags_out;
  int                   fail_count = 0;
  int                   compares = 0;
  int                   i;
  int                   j;
  int                   mon_bits = 0;
  logic [7:0]           mon_sh;
  logic [7:0]           rx_q[$];
  logic                 nack_seen;
  logic [7:0]           exp_b;

  // ==========================================================================
  // write scenarios: cmd, param, expected {measure, clean, save}
  logic [7:0] wr_cmd [N_WR] = '{CMD_MEASURE, CMD_CLEAN, CMD_POWER_SAVE, CMD_POWER_SAVE,
                                 CMD_MEASURE, CMD_MEASURE, CMD_CLEAN, CMD_POWER_SAVE};
  logic [7:0] wr_par [N_WR] = '{PARAM_ON, PARAM_ON, PARAM_ON, 8'h03, 8'h05,
                                 PARAM_OFF, PARAM_OFF, PARAM_OFF};
  logic [2:0] wr_exp [N_WR] = '{3'h4, 3'h6, 3'h7, 3'h7, 3'h7, 3'h3, 3'h1, 3'h0};
  logic [7:0] rd_cmd [2]    = '{CMD_READ_COUNT, CMD_READ_MASS};

  always #(CLK_PERIOD_NS / 2) core_clk_in = ~core_clk_in;

  // ==========================================================================
  // design and checker
  psic_i2c_if psic_i2c_if_i ();

  psic_host_end psic_host_end_i (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .bus         (psic_i2c_if_i.host),
    .req_valid_in(req_valid_in),
    .req_cmd_in  (req_cmd_in),
    .req_param_in(req_param_in),
    .ready_out   (ready_out),
    .rd_data_out (rd_data_out),
    .rd_valid_out(rd_valid_out),
    .done_out    (done_out),
    .nack_out    (nack_out)
  );

  psic_sensor_end psic_sensor_end_i (
    .core_clk_in               (core_clk_in),
    .srst_in                   (srst_in),
    .bus                       (psic_i2c_if_i.sensor),
    .particle_count_bins_in    (count_bins),
    .mass_concentration_bins_in(mass_bins),
    .fan_on_in                 (fan_on_in),
    .measure_en_out            (measure_en_out),
    .cleaning_en_out           (cleaning_en_out),
    .power_saving_state_out    (save_out),
    .function_state_flags_out  (flags_out)
  );

  psic_asserts psic_asserts_i (
    .core_clk_in  (core_clk_in),
    .srst_in      (srst_in),
    .host_scl_out (psic_i2c_if_i.host_scl_out),
    .host_scl_oe_n(psic_i2c_if_i.host_scl_oe_n),
    .host_sda_out (psic_i2c_if_i.host_sda_out),
    .host_sda_oe_n(psic_i2c_if_i.host_sda_oe_n),
    .dev_sda_out  (psic_i2c_if_i.dev_sda_out),
    .dev_sda_oe_n (psic_i2c_if_i.dev_sda_oe_n),
    .scl          (psic_i2c_if_i.scl),
    .sda          (psic_i2c_if_i.sda)
  );

  // ==========================================================================
  // wire monitor: first byte after each start
  always @(negedge psic_i2c_if_i.sda) begin
    if (psic_i2c_if_i.scl === 1'b1) begin
      mon_bits = 0;
    end
  end

  always @(posedge psic_i2c_if_i.scl) begin
    if (mon_bits < 8) begin
      mon_sh = {mon_sh[6:0], psic_i2c_if_i.sda};
    end
    mon_bits++;
  end

  // ==========================================================================
  // tasks
  task automatic finish_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask: finish_test

  task automatic hang();
    fail_count++;
    $display("mismatch at %0t: wait ran out", $time);
    finish_test();
  endtask: hang

  task automatic check_flag(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask: check_flag

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask: check_byte

  // one whole transfer: request, then collect bytes until done
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] par, input logic fan);
    int n;
    n = 0;
    @(negedge core_clk_in);
    while (ready_out !== 1'b1) begin
      @(negedge core_clk_in);
      n++;
      if (n > 1000) hang();
    end
    @(posedge core_clk_in);
    req_valid_in <= 1'b1;
    req_cmd_in   <= cmd;
    req_param_in <= par;
    fan_on_in    <= fan;
    @(posedge core_clk_in);
    req_valid_in <= 1'b0;
    rx_q.delete();
    nack_seen = 1'b0;
    n = 0;
    forever begin
      @(negedge core_clk_in);
      if (rd_valid_out === 1'b1) rx_q.push_back(rd_data_out);
      if (nack_out === 1'b1) nack_seen = 1'b1;
      if (done_out === 1'b1) break;
      n++;
      if (n > XFER_MAX) hang();
    end
  endtask: xfer

  // ==========================================================================
  // main sequence
  initial begin
    srst_in      = 1'b1;
    req_valid_in = 1'b0;
    req_cmd_in   = 8'h00;
    req_param_in = 8'h00;
    fan_on_in    = 1'b0;
    mon_sh       = 8'h00;
    for (j = 0; j < BIN_COUNT * BIN_BYTES; j++) begin
      count_bins[BIN_VEC_W-1-8*j -: 8] = 8'(8'h01 + j);
      mass_bins[BIN_VEC_W-1-8*j -: 8]  = 8'(8'hC0 - j);
    end
    repeat (20) @(posedge core_clk_in);
    srst_in <= 1'b0;
    @(negedge core_clk_in);
    check_flag(ready_out, 1'b0, "ready in reset");
    check_byte({5'h00, measure_en_out, cleaning_en_out, save_out}, 8'h00, "ctrl reset");
    check_byte({5'h00, flags_out}, {5'h00, FLAGS_RST}, "flags reset");
    for (i = 0; i < N_WR; i++) begin
      xfer(wr_cmd[i], wr_par[i], 1'(i % 2));
      check_flag(nack_seen, 1'b0, "write nack");
      check_byte(mon_sh, {PSIC_ADDR_BYTE[7:1], 1'b0}, "write addr");
      check_flag(psic_i2c_if_i.sda & psic_i2c_if_i.scl, 1'b1, "idle lines");
      check_flag(measure_en_out, wr_exp[i][2], "measure");
      check_flag(cleaning_en_out, wr_exp[i][1], "cleaning");
      check_flag(save_out, wr_exp[i][0], "saving");
      exp_b = {5'h00, wr_exp[i][0], wr_exp[i][1], 1'(i % 2)};
      check_byte({5'h00, flags_out}, exp_b, "flags");
      $display("test write %0d done", i);
    end
    for (i = 0; i < 2; i++) begin
      xfer(rd_cmd[i], PARAM_OFF, 1'b0);
      check_flag(nack_seen, 1'b0, "read nack");
      check_byte(mon_sh, {PSIC_ADDR_BYTE[7:1], 1'b1}, "read addr");
      check_byte(8'(rx_q.size()), {2'h0, READ_LEN}, "read length");
      for (j = 0; j < rx_q.size(); j++) begin
        exp_b = (j >= BIN_COUNT * BIN_BYTES) ? BYTE_ZERO :
                (i == 0) ? 8'(8'h01 + j) : 8'(8'hC0 - j);
        check_byte(rx_q[j], exp_b, "read byte");
      end
      check_byte({5'h00, measure_en_out, cleaning_en_out, save_out}, 8'h00, "read ctrl");
      $display("test read %0d done", i);
    end
    finish_test();
  end

endmodule: tb_top
